// >>> verilog/pfm_pkg.sv
// Package for the power and fan fault monitor: register map, status
// and event field layout, reset values and timing constants.
// Assumes a 20 MHz monitor clock and a 32-bit APB register bus.
package pfm_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned FAN_POSITIONS = 4;
  localparam int unsigned SAMPLE_INTERVAL_MS = 1000;
  localparam int unsigned SHUTDOWN_DELAY_S = 30;
  // Every fan is visited once per interval, so one step is a quarter of it
  localparam int unsigned STEP_CYCLES =
    (SAMPLE_INTERVAL_MS * (CLK_HZ / 1000)) / FAN_POSITIONS;
  localparam int unsigned SHUTDOWN_CYCLES = SHUTDOWN_DELAY_S * CLK_HZ;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_SNAPSHOT = 8'h04;
  localparam logic [7:0] OFS_EVENT = 8'h08;
  localparam logic [7:0] OFS_ID_MEM = 8'h40;
  localparam int unsigned ID_MEM_WORDS = 16;

  // ----------------------------------------------------------------
  // Status word fields (live and snapshot share one layout)
  // ----------------------------------------------------------------
  localparam int ST_RAILS = 0;
  localparam int ST_SUPPLY = 1;
  localparam int ST_THERMAL = 4;
  localparam int ST_CPU_COOL = 5;
  localparam int ST_CHASSIS = 6;
  localparam int ST_CPU_FAIL = 8;
  localparam int ST_SYS_FAIL = 12;
  localparam int ST_HALT = 16;
  localparam int ST_POS = 20;
  localparam int ST_PRESENT = 24;
  localparam int ST_FROZEN = 31;

  // ----------------------------------------------------------------
  // Event word fields (write one to clear)
  // ----------------------------------------------------------------
  localparam int EV_CPU_FAN = 0;
  localparam int EV_SYS_FAN = 1;
  localparam int EV_OVERTEMP = 2;
  localparam int EV_SUPPLY = 3;
  localparam int EV_WIDTH = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SNAPSHOT_RESET = 32'h00000000;
  localparam logic [3:0] EVENT_RESET = 4'h0;
  localparam logic [1:0] POS_RESET = 2'h0;

endpackage

// >>> verilog/pfm_pin_sync.sv
// Three-stage synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are slow levels; a change counts once the second
// and third stages agree, which also rejects a one-cycle glitch.
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] pin,
  output var logic [W-1:0] level
);
  // ----------------------------------------------------------------
  // Per-bit stages
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // First stage feeds only the second stage
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          level[i] <= 1'b0;
        end else if (ce) begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level[i] <= s3;
          end
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> verilog/pfm_monitor.sv
// Power and fan fault monitor: status indicators, round-robin fan
// sampling, fault snapshot, shutdown alert and delayed power removal.
// Assumes all sense inputs are asynchronous pins and the maintenance
// controller reaches the registers over APB with one clock (MCLK).
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - dc_rails_good lit only while both main rails are within limits.
// - Supply good lit when supply present and its power-good is asserted.
// - Supply good indicator stays off when that supply is absent.
// - thermal_good lit while temperature is below threshold, else off.
// - CPU fan failure drops processor_cooling_good, keeps position lit.
// - System fan failure drops chassis_cooling_good, keeps pair lit.
// - Pair 0 to 2 indicator lit while sampled or either fan failed.
// - Position indicator off when not sampled and its fans work.
// - Position 3 indicator lit while CPU fan 3 sampled or failed.
// - Status register of fan and supply state, latched on a fault.
// - Second register raises bus interrupt on fan, thermal, supply fault.
// - Controller is the only master; this block only answers.
// - Halt button position is readable over the bus.
// - Bus readable and writable identity memory for module data.
// - Each fan is checked once per one-second sampling interval.
// - Shutdown asserted a fixed delay after overheat or lost cooling.
module pfm_monitor
  import pfm_pkg::*;
#(
  parameter int unsigned STEP_LEN = STEP_CYCLES,
  parameter int unsigned SHUTDOWN_LEN = SHUTDOWN_CYCLES
) (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output var logic [31:0] PRDATA,
  output var logic PREADY,
  output var logic PSLVERR,
  // Sense pins
  input wire logic RAIL5_IN_LIMITS,
  input wire logic RAIL3_IN_LIMITS,
  input wire logic [2:0] SUPPLY_PRESENT,
  input wire logic [2:0] SUPPLY_POWER_GOOD,
  input wire logic OVER_TEMP,
  input wire logic [3:0] CPU_FAN_OK,
  input wire logic [2:0] SYS_FAN_OK,
  input wire logic HALT_BUTTON_IN,
  // Indicators and alerts
  output var logic DC_RAILS_GOOD,
  output var logic SUPPLY0_GOOD,
  output var logic SUPPLY1_GOOD,
  output var logic SUPPLY2_GOOD,
  output var logic THERMAL_GOOD,
  output var logic PROCESSOR_COOLING_GOOD,
  output var logic CHASSIS_COOLING_GOOD,
  output var logic FAN_PAIR0_SAMPLE,
  output var logic FAN_PAIR1_SAMPLE,
  output var logic FAN_PAIR2_SAMPLE,
  output var logic CPU_COOLER3_SAMPLE,
  output var logic MAINT_IRQ,
  output var logic POWER_FAULT_SHUTDOWN_N
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  localparam int NPIN = 20;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_sync;
  assign pin_raw = {HALT_BUTTON_IN, SYS_FAN_OK, CPU_FAN_OK, OVER_TEMP,
                    SUPPLY_POWER_GOOD, SUPPLY_PRESENT, RAIL3_IN_LIMITS,
                    RAIL5_IN_LIMITS, 3'h0};

  pfm_pin_sync #(.W(NPIN)) u_sync (
    .clk(MCLK),
    .rst(RESET),
    .ce(CE),
    .pin(pin_raw),
    .level(pin_sync)
  );

  wire rail5_ok = pin_sync[3];
  wire rail3_ok = pin_sync[4];
  wire [2:0] present = pin_sync[7:5];
  wire [2:0] power_good = pin_sync[10:8];
  wire over_temp = pin_sync[11];
  wire [3:0] cpu_fan_ok = pin_sync[15:12];
  wire [2:0] sys_fan_ok = pin_sync[18:16];
  wire halt_in = pin_sync[19];

  // ----------------------------------------------------------------
  // Fan sampling state
  // ----------------------------------------------------------------
  logic [31:0] step_cnt;
  logic [1:0] sample_pos;
  logic [3:0] cpu_fail;
  logic [2:0] sys_fail;
  wire step_done = (step_cnt == STEP_LEN - 1);
  wire [1:0] next_pos = sample_pos + 2'h1;
  wire cur_cpu_bad = ~cpu_fan_ok[sample_pos];
  // Position 3 carries only a CPU fan
  wire cur_sys_bad = (sample_pos != 2'h3) && ~sys_fan_ok[sample_pos[1:0] == 2'h3 ?
                     2'h0 : sample_pos];

  // Step timer: four steps make one full sampling interval
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      step_cnt <= 32'h00000000;
      sample_pos <= POS_RESET;
    end else if (CE) begin
      if (step_done) begin
        step_cnt <= 32'h00000000;
        sample_pos <= next_pos; // wraps 3 -> 0
      end else begin
        step_cnt <= step_cnt + 32'h00000001;
      end
    end
  end

  // Failures stick until reset; a fan that stalls once is not trusted again
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      cpu_fail <= 4'h0;
      sys_fail <= 3'h0;
    end else if (CE && step_done) begin
      if (cur_cpu_bad) begin
        cpu_fail[sample_pos] <= 1'b1; // one check per fan per interval
      end
      if (cur_sys_bad) begin
        sys_fail[sample_pos] <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicator decode
  // ----------------------------------------------------------------
  wire rails_good = rail5_ok & rail3_ok;
  wire [2:0] supply_good = present & power_good; // absent forces off
  wire thermal_good = ~over_temp;
  wire cpu_cool_good = ~|cpu_fail;
  wire chassis_good = ~|sys_fail;
  logic [3:0] pos_lit;
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pair
      // Sampled now, or either fan of the pair has failed
      assign pos_lit[p] = (sample_pos == p) | cpu_fail[p] | sys_fail[p];
    end
  endgenerate
  assign pos_lit[3] = (sample_pos == 2'h3) | cpu_fail[3];

  // Indicators are registered so every output comes from a flip-flop
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      DC_RAILS_GOOD <= 1'b0;
      {SUPPLY2_GOOD, SUPPLY1_GOOD, SUPPLY0_GOOD} <= 3'h0;
      THERMAL_GOOD <= 1'b0;
      PROCESSOR_COOLING_GOOD <= 1'b0;
      CHASSIS_COOLING_GOOD <= 1'b0;
      {CPU_COOLER3_SAMPLE, FAN_PAIR2_SAMPLE, FAN_PAIR1_SAMPLE, FAN_PAIR0_SAMPLE} <= 4'h0;
    end else if (CE) begin
      DC_RAILS_GOOD <= rails_good;
      {SUPPLY2_GOOD, SUPPLY1_GOOD, SUPPLY0_GOOD} <= supply_good;
      THERMAL_GOOD <= thermal_good;
      PROCESSOR_COOLING_GOOD <= cpu_cool_good;
      CHASSIS_COOLING_GOOD <= chassis_good;
      {CPU_COOLER3_SAMPLE, FAN_PAIR2_SAMPLE, FAN_PAIR1_SAMPLE, FAN_PAIR0_SAMPLE} <= pos_lit;
    end
  end

  // ----------------------------------------------------------------
  // Fault conditions
  // ----------------------------------------------------------------
  // Supply faults count only once the rails have been good, so the
  // power-up ramp does not freeze a meaningless snapshot
  logic rails_seen;
  wire supply_bad = rails_seen & (~rails_good | |(present & ~power_good));
  wire [EV_WIDTH-1:0] ev_cond = {supply_bad, over_temp, |sys_fail, |cpu_fail};
  wire fault_now = |ev_cond;
  wire cooling_lost = over_temp | |cpu_fail | |sys_fail;

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  logic snap_frozen;
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h00000000;
    status_word[ST_RAILS] = rails_good;
    status_word[ST_SUPPLY +: 3] = supply_good;
    status_word[ST_THERMAL] = thermal_good;
    status_word[ST_CPU_COOL] = cpu_cool_good;
    status_word[ST_CHASSIS] = chassis_good;
    status_word[ST_CPU_FAIL +: 4] = cpu_fail;
    status_word[ST_SYS_FAIL +: 3] = sys_fail;
    status_word[ST_HALT] = halt_in;
    status_word[ST_POS +: 2] = sample_pos;
    status_word[ST_PRESENT +: 3] = present;
    status_word[ST_FROZEN] = snap_frozen;
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // The block never starts a transfer; it only answers the controller
  wire setup_phase = PSEL & ~PENABLE;
  wire access_done = PSEL & PENABLE & PREADY;
  wire wr_done = access_done & PWRITE;
  wire hit_status = (PADDR == OFS_STATUS);
  wire hit_snapshot = (PADDR == OFS_SNAPSHOT);
  wire hit_event = (PADDR == OFS_EVENT);
  wire hit_mem = (PADDR[7:6] == OFS_ID_MEM[7:6]) && (PADDR[1:0] == 2'h0);
  wire addr_ok = hit_status | hit_snapshot | hit_event | hit_mem;
  wire [3:0] mem_idx = PADDR[5:2];

  // ----------------------------------------------------------------
  // Fault snapshot
  // ----------------------------------------------------------------
  logic [31:0] snapshot;
  logic fault_prev;
  wire fault_rise = fault_now & ~fault_prev;
  wire rearm = wr_done & hit_snapshot;

  // First fault freezes a copy; a write to the snapshot rearms it.
  // A fault in the rearm cycle still captures, so nothing is lost.
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      snapshot <= SNAPSHOT_RESET;
      snap_frozen <= 1'b0;
      fault_prev <= 1'b0;
      rails_seen <= 1'b0;
    end else if (CE) begin
      fault_prev <= fault_now;
      rails_seen <= rails_seen | rails_good;
      if (fault_rise && (!snap_frozen || rearm)) begin
        snapshot <= status_word;
        snap_frozen <= 1'b1;
      end else if (rearm) begin
        snap_frozen <= 1'b0;
      end else if (!snap_frozen) begin
        snapshot <= status_word; // tracks live state until a fault
      end
    end
  end

  // ----------------------------------------------------------------
  // Shutdown alert register
  // ----------------------------------------------------------------
  logic [EV_WIDTH-1:0] events;
  wire [EV_WIDTH-1:0] ev_clear = (wr_done && hit_event) ? PWDATA[EV_WIDTH-1:0] :
                                 {EV_WIDTH{1'b0}};

  // Sticky until a one is written; a set in the clear cycle wins
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      events <= EVENT_RESET;
      MAINT_IRQ <= 1'b0;
    end else if (CE) begin
      events <= (events & ~ev_clear) | ev_cond;
      MAINT_IRQ <= |((events & ~ev_clear) | ev_cond);
    end
  end

  // ----------------------------------------------------------------
  // Delayed power removal
  // ----------------------------------------------------------------
  logic [31:0] sd_cnt;

  // The timer restarts if the cause clears; once fired it holds until reset
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      sd_cnt <= 32'h00000000;
      POWER_FAULT_SHUTDOWN_N <= 1'b1;
    end else if (CE) begin
      if (!cooling_lost) begin
        sd_cnt <= 32'h00000000;
      end else if (sd_cnt == SHUTDOWN_LEN - 1) begin
        POWER_FAULT_SHUTDOWN_N <= 1'b0;
      end else begin
        sd_cnt <= sd_cnt + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Identity memory
  // ----------------------------------------------------------------
  // Holds module type, serial, revisions and the saved fault words.
  // Not reset: its contents belong to software, not to the block.
  logic [31:0] id_mem [ID_MEM_WORDS];
  always_ff @(posedge MCLK) begin
    if (CE && wr_done && hit_mem) begin
      id_mem[mem_idx] <= PWDATA;
    end
  end

  // ----------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (hit_status) begin
      rd_mux = status_word;
    end else if (hit_snapshot) begin
      rd_mux = snapshot;
    end else if (hit_event) begin
      rd_mux = {{(32 - EV_WIDTH){1'b0}}, events};
    end else if (hit_mem) begin
      rd_mux = id_mem[mem_idx];
    end
  end

  // Answer is prepared in setup so the access phase ends with no wait
  always_ff @(posedge MCLK or posedge RESET) begin
    if (RESET) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= setup_phase;
      PSLVERR <= setup_phase & ~addr_ok;
      if (setup_phase) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/pfm_monitor_assertions.sv
// Checker for the fault monitor; sees only the top module's ports.
// Assumes CE high during traffic and a short step count.
`timescale 1ns/1ps
`default_nettype none
module pfm_monitor_chk (
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic RAIL5_IN_LIMITS,
  input wire logic RAIL3_IN_LIMITS,
  input wire logic [2:0] SUPPLY_PRESENT,
  input wire logic [2:0] SUPPLY_POWER_GOOD,
  input wire logic OVER_TEMP,
  input wire logic DC_RAILS_GOOD,
  input wire logic SUPPLY0_GOOD,
  input wire logic SUPPLY1_GOOD,
  input wire logic THERMAL_GOOD,
  input wire logic PROCESSOR_COOLING_GOOD,
  input wire logic CHASSIS_COOLING_GOOD,
  input wire logic FAN_PAIR0_SAMPLE,
  input wire logic FAN_PAIR1_SAMPLE,
  input wire logic FAN_PAIR2_SAMPLE,
  input wire logic CPU_COOLER3_SAMPLE,
  input wire logic MAINT_IRQ,
  input wire logic POWER_FAULT_SHUTDOWN_N
);
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  wire logic [3:0] leds = {CPU_COOLER3_SAMPLE, FAN_PAIR2_SAMPLE, FAN_PAIR1_SAMPLE,
    FAN_PAIR0_SAMPLE};
  wire logic cool_ok = PROCESSOR_COOLING_GOOD && CHASSIS_COOLING_GOOD;
  wire logic cool_lost = !THERMAL_GOOD || !cool_ok;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // --------------------------------------------------------------
  // Properties; six stable samples cover the pin synchroniser
  // --------------------------------------------------------------
  chk_rails_on:
    assert property ((CE && RAIL5_IN_LIMITS && RAIL3_IN_LIMITS)[*6] |=> DC_RAILS_GOOD)
      else $error("rails indicator off with both rails good");
  chk_supply_on:
    assert property ((CE && SUPPLY_PRESENT[0] && SUPPLY_POWER_GOOD[0])[*6] |=> SUPPLY0_GOOD)
      else $error("supply indicator off with supply good");
  chk_supply_absent:
    assert property ((CE && !SUPPLY_PRESENT[1])[*6] |=> !SUPPLY1_GOOD)
      else $error("supply indicator lit for absent supply");
  chk_thermal_off:
    assert property ((CE && OVER_TEMP)[*6] |=> !THERMAL_GOOD)
      else $error("thermal indicator lit while hot");
  // A stuck lamp means neighbouring samples always share a lit bit
  chk_cpu_fail_lamp:
    assert property ($fell(PROCESSOR_COOLING_GOOD) |=>
      (!PROCESSOR_COOLING_GOOD && (|(leds & $past(leds))))[*8])
      else $error("cpu fan failure not held");
  chk_sys_fail_lamp:
    assert property ($fell(CHASSIS_COOLING_GOOD) |=>
      (!CHASSIS_COOLING_GOOD && (|(leds[2:0] & $past(leds[2:0]))))[*8])
      else $error("system fan failure not held");
  chk_led_onehot:
    assert property (cool_ok |-> $onehot(leds))
      else $error("sample lamps not one hot with fans good");
  chk_rr_order:
    assert property (cool_ok && $rose(FAN_PAIR1_SAMPLE) |-> $past(FAN_PAIR0_SAMPLE))
      else $error("position 1 not reached from position 0");
  chk_irq_thermal:
    assert property ($fell(THERMAL_GOOD) |=> MAINT_IRQ[*3])
      else $error("no interrupt on overheat");
  chk_shutdown_cause:
    assert property ($fell(POWER_FAULT_SHUTDOWN_N) |-> $past(cool_lost, 40))
      else $error("shutdown without lasting cause");
  chk_apb_ready:
    assert property (CE && PSEL && !PENABLE |=> PREADY && !(PSLVERR && !PREADY))
      else $error("access phase not answered at once");
endmodule
bind pfm_monitor pfm_monitor_chk chk_u (.MCLK(MCLK), .RESET(RESET), .CE(CE), .PSEL(PSEL),
  .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .RAIL5_IN_LIMITS(RAIL5_IN_LIMITS),
  .RAIL3_IN_LIMITS(RAIL3_IN_LIMITS), .SUPPLY_PRESENT(SUPPLY_PRESENT),
  .SUPPLY_POWER_GOOD(SUPPLY_POWER_GOOD), .OVER_TEMP(OVER_TEMP), .DC_RAILS_GOOD(DC_RAILS_GOOD),
  .SUPPLY0_GOOD(SUPPLY0_GOOD), .SUPPLY1_GOOD(SUPPLY1_GOOD), .THERMAL_GOOD(THERMAL_GOOD),
  .PROCESSOR_COOLING_GOOD(PROCESSOR_COOLING_GOOD), .CHASSIS_COOLING_GOOD(CHASSIS_COOLING_GOOD),
  .FAN_PAIR0_SAMPLE(FAN_PAIR0_SAMPLE), .FAN_PAIR1_SAMPLE(FAN_PAIR1_SAMPLE),
  .FAN_PAIR2_SAMPLE(FAN_PAIR2_SAMPLE), .CPU_COOLER3_SAMPLE(CPU_COOLER3_SAMPLE),
  .MAINT_IRQ(MAINT_IRQ), .POWER_FAULT_SHUTDOWN_N(POWER_FAULT_SHUTDOWN_N));
`default_nettype wire

// >>> testbench/pfm_maint_ctrl.sv
// Maintenance controller model: the only APB master of the monitor.
// Assumes MCLK is shared; waits for PREADY under a fixed bound.
`timescale 1ns/1ps
`default_nettype none
module pfm_maint_ctrl (
  input wire logic mclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  output var logic psel,
  output var logic penable,
  output var logic pwrite,
  output var logic [7:0] paddr,
  output var logic [31:0] pwdata
);
  // Idle bus at time zero
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer; every access, reads and writes alike, starts here
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic er, output logic late);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    er = pslverr;
    late = (pready !== 1'h1);
    // Address and data lines flip so a stale value never looks valid
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~wd;
  endtask
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the fault monitor and the controller model.
// Assumes short step and shutdown counts so the run stays brief.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pfm_pkg::*;
  localparam int STEP = 8;
  localparam int SHUT = 50;
  logic mclk, reset, ce, halt, r5, r3, temp, psel, penable, pwrite, pready, pslverr;
  logic dc, s0, s1, s2, tg, pcg, ccg, irq, shut_n, err, late;
  logic [2:0] pres, pgood, sys_ok;
  logic [3:0] cpu_ok, leds, acc;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, word;
  int fail_count, checks_done, n;
  // Rows: {rail5, rail3, present, power good, hot} and {rails, s0, s1, s2, thermal}
  logic [8:0] row_in [5] = '{9'h1FE, 9'h0FE, 9'h17E, 9'h1AE, 9'h1FB};
  logic [4:0] row_exp [5] = '{5'h1F, 5'h0F, 5'h0F, 5'h15, 5'h1A};

  pfm_monitor #(.STEP_LEN(STEP), .SHUTDOWN_LEN(SHUT)) dut_u (.MCLK(mclk), .RESET(reset),
    .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .RAIL5_IN_LIMITS(r5),
    .RAIL3_IN_LIMITS(r3), .SUPPLY_PRESENT(pres), .SUPPLY_POWER_GOOD(pgood), .OVER_TEMP(temp),
    .CPU_FAN_OK(cpu_ok), .SYS_FAN_OK(sys_ok), .HALT_BUTTON_IN(halt), .DC_RAILS_GOOD(dc),
    .SUPPLY0_GOOD(s0), .SUPPLY1_GOOD(s1), .SUPPLY2_GOOD(s2), .THERMAL_GOOD(tg),
    .PROCESSOR_COOLING_GOOD(pcg), .CHASSIS_COOLING_GOOD(ccg), .FAN_PAIR0_SAMPLE(leds[0]),
    .FAN_PAIR1_SAMPLE(leds[1]), .FAN_PAIR2_SAMPLE(leds[2]), .CPU_COOLER3_SAMPLE(leds[3]),
    .MAINT_IRQ(irq), .POWER_FAULT_SHUTDOWN_N(shut_n));
  pfm_maint_ctrl ctrl_u (.mclk(mclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ------------------------------------------------------------
  // Clock and shared tasks
  // ------------------------------------------------------------
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A stalled answer ends the run at once
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    ctrl_u.xfer(wr, a, wd, word, err, late);
    if (late) begin
      fail_count++;
      finish_test();
    end
  endtask
  // Waits for one lamp pattern; n is left holding the cycles taken
  task automatic wait_leds(input logic [3:0] v);
    n = 0;
    while (leds !== v && n < 200) begin
      tick(1);
      n++;
    end
    compare("lamps", {28'h0, v}, {28'h0, leds});
    if (n >= 200) finish_test();
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    reset = 1'h1;
    ce = 1'h1;
    halt = 1'h1;
    {r5, r3, pres, pgood, temp} = row_in[0];
    cpu_ok = 4'hF;
    sys_ok = 3'h7;
    fail_count = 0;
    checks_done = 0;
    tick(4);
    reset <= 1'h0;
    tick(8);
    compare("shutdown idle", 32'h1, {31'h0, shut_n});
    bus(1'h0, OFS_EVENT, 32'h0);
    compare("event reset", 32'h0, word);
    bus(1'h0, OFS_STATUS, 32'h0);
    compare("status", 32'h0701007F, word & 32'h7FCFFFFF);
    halt <= 1'h0;
    tick(8);
    bus(1'h0, OFS_STATUS, 32'h0);
    compare("halt out", 32'h0, word & 32'h00010000);
    bus(1'h1, 8'h0C, 32'hFFFFFFFF);
    compare("unmapped err", 32'h1, {31'h0, err});
    bus(1'h0, 8'h0C, 32'h0);
    compare("unmapped read", 32'h0, word);
    bus(1'h1, OFS_ID_MEM, 32'hA5C30F12);
    bus(1'h1, 8'h7C, 32'h12345678);
    bus(1'h0, OFS_ID_MEM, 32'h0);
    compare("id first", 32'hA5C30F12, word);
    bus(1'h0, 8'h7C, 32'h0);
    compare("id last", 32'h12345678, word);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      {r5, r3, pres, pgood, temp} <= row_in[i];
      tick(8);
      compare("lamps row", {27'h0, row_exp[i]}, {27'h0, dc, s0, s1, s2, tg});
      $display("row %0d done", i);
    end
    {r5, r3, pres, pgood, temp} <= row_in[0];
    tick(8);
    // Rail loss, missing power good and heat have all been seen
    bus(1'h0, OFS_EVENT, 32'h0);
    compare("event set", 32'hC, word);
    compare("irq set", 32'h1, {31'h0, irq});
    bus(1'h1, OFS_EVENT, 32'hF);
    bus(1'h0, OFS_EVENT, 32'h0);
    compare("event clear", 32'h0, word);
    compare("irq clear", 32'h0, {31'h0, irq});
    // The copy keeps the rail loss; the frozen flag shows in live status only
    bus(1'h0, OFS_SNAPSHOT, 32'h0);
    compare("snapshot rail", 32'h0, word & 32'h1);
    bus(1'h0, OFS_STATUS, 32'h0);
    compare("snapshot frozen", 32'h80000001, word & 32'h80000001);
    bus(1'h1, OFS_SNAPSHOT, 32'h0);
    bus(1'h0, OFS_STATUS, 32'h0);
    compare("snapshot rearm", 32'h0, word & 32'h80000000);
    $display("event test done");
    wait_leds(4'h1);
    wait_leds(4'h2);
    wait_leds(4'h4);
    compare("step length", STEP, n);
    wait_leds(4'h8);
    compare("step length", STEP, n);
    wait_leds(4'h1);
    // Clock enable low must hold the sampling position
    ce <= 1'h0;
    tick(20);
    compare("frozen lamps", 32'h1, {28'h0, leds});
    ce <= 1'h1;
    $display("sampling test done");
    cpu_ok <= 4'hD;
    sys_ok <= 3'h5;
    n = 0;
    while (pcg === 1'h1 && n < 100) begin
      tick(1);
      n++;
    end
    compare("cooling drop", 32'h0, {31'h0, pcg});
    n = 0;
    acc = 4'hF;
    while (shut_n === 1'h1 && n < 200) begin
      tick(1);
      acc = acc & leds;
      n++;
    end
    compare("shutdown delay", 32'h1, {31'h0, n >= SHUT - 3 && n <= SHUT + 3});
    compare("stuck lamp", 32'h2, {28'h0, acc});
    compare("cooling lost", 32'h0, {30'h0, pcg, ccg});
    cpu_ok <= 4'hF;
    sys_ok <= 3'h7;
    // Controller reads the event, status and snapshot words after the alert
    bus(1'h0, OFS_EVENT, 32'h0);
    compare("fan events", 32'h3, word & 32'h3);
    bus(1'h0, OFS_STATUS, 32'h0);
    compare("fan status", 32'h2200, word & 32'h7F60);
    bus(1'h0, OFS_SNAPSHOT, 32'h0);
    compare("fan snapshot", 32'h2200, word & 32'h7F60);
    $display("fan test done");
    reset <= 1'h1;
    tick(4);
    reset <= 1'h0;
    tick(8);
    compare("shutdown cleared", 32'h1, {31'h0, shut_n});
    compare("cooling back", 32'h3, {30'h0, pcg, ccg});
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
